// ### src/img_gen.sv
// interrupt message generator: vector fetch, message send with retry, slave port
// assumes the bridge end of img_if shares i_ref_clk; controller pins are plain ports
// Functional notes
// - messages use message type code 0011b
// - designator top byte, vector next byte
// - module field picks processor, internal priority
// - bridge accepts priority 31 or higher
// - one-word write, resend on rejection
// - two acknowledge pulses fetch vector
// - slave access to controller and ram
// - generator default owner; others hold-request
// - address strobe marks address phase
// - byte lane enables ignored
// - reset to idle, messages masked
// - slave only when select asserted
// - controller request synchronised first
// - strobe with address, data next clock
// - bridge delays ready, flags rejection
// - bridge slave timing, write then read
// - latch vector after second pulse
// - delay counter suits slow controller
// - ram 32 bits, two words each
// - address latch and incrementer
// - decoder: ram, controller, mask, unmask
// - mask bit blocks messages, not writes
// - vector shifted left one for address
// - strobes qualified by bridge direction
module img_gen (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // bridge link
    img_if.gen bus,
    // interrupt controller
    input wire logic i_pic_req,
    input wire logic [7:0] i_pic_data,
    output logic o_pic_ack_pulse,
    output logic o_pic_rd,
    output logic o_pic_wr,
    output logic o_pic_cs,
    output logic o_pic_a0,
    output logic [7:0] o_pic_data,
    output logic o_pic_data_oe,
    // status
    output logic o_masked
);
    // state machine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_A0, ST_A1, ST_DA0, ST_DA1, ST_BW,
        ST_IM0, ST_IM1, ST_CK, ST_IA, ST_II, ST_VF0, ST_VF1
    } img_state_e;

    // all registered state
    typedef struct packed {
        img_state_e st;
        logic req_s1;                       // first sync stage
        logic req_s2;                       // second sync stage
        logic [3:0] dly;                    // controller timing counter
        logic [img_pkg::RAM_AW-1:0] addr;   // address latch and incrementer
        logic [31:0] slv_addr;              // latched bridge address
        logic slv_wr;                       // latched direction
        logic masked;                       // mask storage bit
        logic [31:0] lad_o;
        logic lad_oe;
        logic ads_o;
        logic ads_oe;
        logic ready;
        logic grant;
        logic ack;
        logic pic_rd;
        logic pic_wr;
        logic pic_cs;
        logic [7:0] pic_wdata;
        logic pic_oe;
    } img_gen_s;

    img_gen_s r;
    img_gen_s next_r;
    logic [31:0] ram [0:img_pkg::RAM_DEPTH-1];   // message storage
    logic [31:0] ram_q;
    logic ram_we;
    logic [img_pkg::RAM_AW-1:0] ram_wa;

    // region decode of a latched bridge address, used in two states
    function automatic logic [1:0] region(input logic [31:0] a);
        region = a[img_pkg::ASEL_MSB:img_pkg::ASEL_LSB];
    endfunction : region

    // ram word index of a latched bridge address
    function automatic logic [img_pkg::RAM_AW-1:0] word_of(input logic [31:0] a);
        word_of = a[img_pkg::AWORD_LSB +: img_pkg::RAM_AW];
    endfunction : word_of

    // message ram: synchronous write, registered read
    always_ff @(posedge i_ref_clk) begin
        if (ram_we) begin
            ram[ram_wa] <= bus.muxed_addr_data_lines;
        end
        ram_q <= ram[next_r.addr];
    end

    // ram write happens at the end of data access for slave writes
    assign ram_we = (r.st == ST_DA1) && r.slv_wr && (region(r.slv_addr) == img_pkg::SEL_RAM);
    assign ram_wa = word_of(r.slv_addr);

    // next state and outputs
    always_comb begin
        next_r = r;
        next_r.req_s1 = i_pic_req;
        next_r.req_s2 = r.req_s1;
        next_r.ready = 1'b0;
        next_r.ads_o = 1'b0;
        next_r.ads_oe = 1'b0;
        next_r.lad_oe = 1'b0;
        next_r.ack = 1'b0;
        next_r.pic_rd = 1'b0;
        next_r.pic_wr = 1'b0;
        next_r.pic_cs = 1'b0;
        next_r.pic_oe = 1'b0;
        if (r.dly != 4'h0) begin
            next_r.dly = r.dly - 4'h1;
        end
        case (r.st)
            // idle: bridge hold request wins so software can always reach us
            ST_IDLE: begin
                if (bus.bus_hold_request) begin
                    next_r.st = ST_A0;
                    next_r.grant = 1'b1;
                end else if (r.req_s2 && !r.masked) begin
                    next_r.st = ST_IA;
                    next_r.ack = 1'b1;
                    next_r.dly = img_pkg::PIC_SETUP_CYC;
                end
            end
            // address phase recognised by strobe, no separate latch enable
            ST_A0: begin
                if (bus.address_strobe) begin
                    next_r.slv_addr = bus.muxed_addr_data_lines;
                    next_r.addr = word_of(bus.muxed_addr_data_lines);
                    next_r.slv_wr = bus.wr_n_brg;
                    next_r.st = ST_A1;
                end else if (!bus.bus_hold_request) begin
                    next_r.st = ST_BW;
                end
            end
            // wait for select; a released hold ends the tenure
            ST_A1: begin
                if (bus.sel) begin
                    next_r.st = ST_DA0;
                    next_r.dly = img_pkg::PIC_SETUP_CYC;
                end else if (!bus.bus_hold_request) begin
                    next_r.st = ST_BW;
                end else if (bus.address_strobe) begin
                    next_r.slv_addr = bus.muxed_addr_data_lines;
                    next_r.addr = word_of(bus.muxed_addr_data_lines);
                    next_r.slv_wr = bus.wr_n_brg;
                end
            end
            // access window; strobes follow bridge direction
            ST_DA0: begin
                if (region(r.slv_addr) == img_pkg::SEL_PIC) begin
                    next_r.pic_cs = 1'b1;
                    next_r.pic_rd = !r.slv_wr;
                    next_r.pic_wr = r.slv_wr;
                    next_r.pic_oe = r.slv_wr;
                    next_r.pic_wdata = bus.muxed_addr_data_lines[7:0];
                end
                if (r.dly == 4'h0) begin
                    next_r.st = ST_DA1;
                    next_r.ready = 1'b1;
                    if (!r.slv_wr) begin
                        next_r.lad_oe = 1'b1;
                        next_r.lad_o = (region(r.slv_addr) == img_pkg::SEL_PIC)
                            ? {24'h00_0000, i_pic_data} : ram_q;
                    end
                end
            end
            // finish transfer, apply commands
            ST_DA1: begin
                if (region(r.slv_addr) == img_pkg::SEL_MASK) begin
                    next_r.masked = 1'b1;
                end else if (region(r.slv_addr) == img_pkg::SEL_UNMASK) begin
                    next_r.masked = 1'b0;
                end
                next_r.st = ST_A0;
            end
            // bridge let go; take the bus back
            ST_BW: begin
                next_r.grant = 1'b0;
                next_r.st = ST_IDLE;
            end
            // first acknowledge pulse
            ST_IA: begin
                next_r.ack = (r.dly != 4'h0);
                if (r.dly == 4'h0) begin
                    next_r.st = ST_II;
                    next_r.dly = img_pkg::PIC_RECOVER_CYC;
                end
            end
            // recovery gap between pulses
            ST_II: begin
                if (r.dly == 4'h0) begin
                    next_r.st = ST_VF0;
                    next_r.ack = 1'b1;
                    next_r.dly = img_pkg::PIC_SETUP_CYC;
                end
            end
            // second pulse; vector latched at its end, shifted for two-word slots
            ST_VF0: begin
                next_r.ack = (r.dly != 4'h0);
                if (r.dly == 4'h0) begin
                    next_r.addr = {i_pic_data, 1'b0};
                    next_r.st = ST_VF1;
                end
            end
            // decode wait lets the ram read settle
            ST_VF1: begin
                next_r.st = ST_IM0;
                next_r.ads_o = 1'b1;
                next_r.ads_oe = 1'b1;
                next_r.lad_oe = 1'b1;
                next_r.lad_o = ram_q; // address word from ram
                next_r.addr = r.addr + 9'h001;
            end
            // address word out, data word next clock
            ST_IM0: begin
                next_r.st = ST_IM1;
                next_r.lad_oe = 1'b1;
                next_r.lad_o = ram_q;
            end
            // hold data until bridge ready; then check rejection
            ST_IM1: begin
                next_r.lad_oe = 1'b1;
                if (bus.ready_brg) begin
                    next_r.st = ST_CK;
                    next_r.lad_oe = 1'b0;
                    next_r.addr = r.addr - 9'h001; // modulo-2 back to slot start
                end
            end
            // rejection arrives the cycle after ready; retry same slot
            ST_CK: begin
                if (bus.message_rejected) begin
                    next_r.st = ST_VF1;
                end else begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    // state register; reset idles and masks
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.masked <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign bus.lad_o_gen = r.lad_o;
    assign bus.lad_oe_gen = r.lad_oe;
    assign bus.ads_o_gen = r.ads_o;
    assign bus.ads_oe_gen = r.ads_oe;
    assign bus.ready_gen = r.ready;
    assign bus.bus_hold_grant = r.grant;
    assign o_pic_ack_pulse = r.ack;
    assign o_pic_rd = r.pic_rd;
    assign o_pic_wr = r.pic_wr;
    assign o_pic_cs = r.pic_cs;
    assign o_pic_a0 = r.slv_addr[img_pkg::AWORD_LSB];
    assign o_pic_data = r.pic_wdata;
    assign o_pic_data_oe = r.pic_oe;
    assign o_masked = r.masked;
endmodule : img_gen

// ### src/img_pkg.sv
// shared constants and types for the interrupt message generator and its bridge end
// assumes one 50 MHz bus clock shared by both ends, synchronous active-low reset
package img_pkg;
    // clock and timing
    localparam int CLK_NS = 20;                  // bus clock period in ns
    localparam int PIC_SETUP_NS = 300;           // slow controller strobe width, least time
    localparam int PIC_RECOVER_NS = 160;         // slow controller recovery, least time
    localparam logic [3:0] PIC_SETUP_CYC = 4'((PIC_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PIC_RECOVER_CYC = 4'((PIC_RECOVER_NS + CLK_NS - 1) / CLK_NS);
    // message word layout
    localparam logic [3:0] MSG_TYPE_CODE = 4'h3;  // message-type code 0011b
    localparam int DESIG_MSB = 31;               // designator in top eight bits
    localparam int DESIG_LSB = 24;
    localparam int VEC_MSB = 23;                 // vector in next eight bits
    localparam int VEC_LSB = 16;
    // message ram
    localparam int RAM_AW = 9;                   // 256 vectors, two words each
    localparam int RAM_DEPTH = 512;
    // local slave address map (word address bits of the latched address)
    localparam logic [1:0] SEL_RAM = 2'h0;
    localparam logic [1:0] SEL_PIC = 2'h1;
    localparam logic [1:0] SEL_MASK = 2'h2;
    localparam logic [1:0] SEL_UNMASK = 2'h3;
    // region field sits above the whole word index, so all 512 words stay reachable
    localparam int ASEL_MSB = 12;                // region select field of address
    localparam int ASEL_LSB = 11;
    localparam int AWORD_LSB = 2;                // word index starts above byte lanes
    localparam logic [0:0] PIC_A0_BIT = 1'h0;
endpackage : img_pkg

// ### src/img_if.sv
// link between the message generator and the bus-extension bridge
// assumes both ends share i_ref_clk; the interface resolves the muxed lines from enables
interface img_if;
    logic [31:0] lad_o_gen;        // muxed lines driven by generator
    logic lad_oe_gen;
    logic [31:0] lad_o_brg;        // muxed lines driven by bridge
    logic lad_oe_brg;
    logic [31:0] muxed_addr_data_lines;              // resolved wire level
    logic ads_o_gen;               // address strobe, generator as master
    logic ads_oe_gen;
    logic ads_o_brg;               // address strobe, bridge as master
    logic ads_oe_brg;
    logic address_strobe;
    logic wr_n_brg;                // bridge direction: 1 = write
    logic [3:0] byte_lane_enables;
    logic ready_brg;               // bridge paces generator; generator answers bridge
    logic ready_gen;
    logic message_rejected;
    logic bus_hold_request;
    logic bus_hold_grant;
    logic sel;
    assign muxed_addr_data_lines = lad_oe_gen ? lad_o_gen : (lad_oe_brg ? lad_o_brg : 32'h0000_0000);
    assign address_strobe = ads_oe_gen ? ads_o_gen : (ads_oe_brg ? ads_o_brg : 1'b0);
    modport gen (output lad_o_gen, lad_oe_gen, ads_o_gen, ads_oe_gen, ready_gen,
        bus_hold_grant, input muxed_addr_data_lines, address_strobe, wr_n_brg, byte_lane_enables, ready_brg,
        message_rejected, bus_hold_request, sel);
    modport brg (output lad_o_brg, lad_oe_brg, ads_o_brg, ads_oe_brg, wr_n_brg,
        byte_lane_enables, ready_brg, message_rejected, bus_hold_request, sel,
        input muxed_addr_data_lines, address_strobe, ready_gen, bus_hold_grant);
endinterface : img_if

// ### src/img_brg.sv
// bridge end: accepts message writes, answers ready/rejection, masters slave accesses
// assumes shared i_ref_clk; user side gives accept decision and access requests
module img_brg (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // link
    img_if.brg bus,
    // message outcome from the far bus
    input wire logic i_msg_accept,
    input wire logic i_msg_nack,
    output logic o_msg_valid,
    output logic [31:0] o_msg_addr,
    output logic [31:0] o_msg_data,
    // slave access requests
    input wire logic i_acc_req,
    input wire logic i_acc_wr,
    input wire logic [31:0] i_acc_addr,
    input wire logic [31:0] i_acc_wdata,
    output logic o_acc_done,
    output logic [31:0] o_acc_rdata
);
    typedef enum logic [2:0] {
        B_IDLE, B_DATA, B_WAIT, B_REJ, B_HOLD, B_ADDR, B_XFER
    } img_brg_state_e;

    typedef struct packed {
        img_brg_state_e st;
        logic [31:0] maddr;
        logic [31:0] mdata;
        logic mvalid;
        logic ready;
        logic rej;
        logic hold;
        logic address_strobe;
        logic [31:0] lad_o;
        logic lad_oe;
        logic wr;
        logic sel;
        logic done;
        logic [31:0] rdata;
    } img_brg_s;

    img_brg_s r;
    img_brg_s next_r;

    always_comb begin
        next_r = r;
        next_r.mvalid = 1'b0;
        next_r.ready = 1'b0;
        next_r.rej = 1'b0;
        next_r.address_strobe = 1'b0;
        next_r.done = 1'b0;
        case (r.st)
            // message strobe or local access request
            B_IDLE: begin
                if (bus.address_strobe && !bus.bus_hold_grant) begin
                    next_r.maddr = bus.muxed_addr_data_lines;
                    next_r.st = B_DATA;
                end else if (i_acc_req && !r.done) begin
                    // the done cycle is skipped: a request still up then is finished
                    next_r.hold = 1'b1;
                    next_r.st = B_HOLD;
                end
            end
            B_DATA: begin
                next_r.mdata = bus.muxed_addr_data_lines;
                next_r.st = B_WAIT;
            end
            // ready only when the far bus answers
            B_WAIT: begin
                if (i_msg_accept || i_msg_nack) begin
                    next_r.ready = 1'b1;
                    next_r.mvalid = i_msg_accept;
                    next_r.st = i_msg_nack ? B_REJ : B_IDLE;
                end
            end
            B_REJ: begin
                next_r.rej = 1'b1;
                next_r.st = B_IDLE;
            end
            // a message may still arrive before the grant; take it first
            B_HOLD: begin
                if (bus.address_strobe && !bus.bus_hold_grant) begin
                    next_r.maddr = bus.muxed_addr_data_lines;
                    next_r.st = B_DATA;
                end else if (bus.bus_hold_grant) begin
                    next_r.address_strobe = 1'b1;
                    next_r.lad_oe = 1'b1;
                    next_r.lad_o = i_acc_addr;
                    next_r.wr = i_acc_wr;
                    next_r.sel = 1'b1;
                    next_r.st = B_ADDR;
                end
            end
            B_ADDR: begin
                next_r.lad_o = i_acc_wdata;
                next_r.lad_oe = r.wr;
                next_r.st = B_XFER;
            end
            B_XFER: begin
                if (bus.ready_gen) begin
                    next_r.rdata = bus.muxed_addr_data_lines;
                    next_r.done = 1'b1;
                    next_r.lad_oe = 1'b0;
                    next_r.sel = 1'b0;
                    next_r.hold = 1'b0;
                    next_r.st = B_IDLE;
                end
            end
            default: begin
                next_r.st = B_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.st <= B_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign bus.lad_o_brg = r.lad_o;
    assign bus.lad_oe_brg = r.lad_oe;
    assign bus.ads_o_brg = r.address_strobe;
    assign bus.ads_oe_brg = r.hold;
    assign bus.wr_n_brg = r.wr;
    assign bus.byte_lane_enables = 4'hF;
    assign bus.ready_brg = r.ready;
    assign bus.message_rejected = r.rej;
    assign bus.bus_hold_request = r.hold;
    assign bus.sel = r.sel;
    assign o_msg_valid = r.mvalid;
    assign o_msg_addr = r.maddr;
    assign o_msg_data = r.mdata;
    assign o_acc_done = r.done;
    assign o_acc_rdata = r.rdata;
endmodule : img_brg

// ### testbench/img_sva.sv
// concurrent checks on the link between the message generator and its bridge
// assumes one clock domain; the bench wires it to the interface signals by name
module img_sva (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // link signals
    input wire logic [31:0] muxed_addr_data_lines,
    input wire logic lad_oe_gen,
    input wire logic lad_oe_brg,
    input wire logic address_strobe,
    input wire logic ads_oe_gen,
    input wire logic ready_brg,
    input wire logic ready_gen,
    input wire logic message_rejected,
    input wire logic bus_hold_request,
    input wire logic bus_hold_grant,
    input wire logic sel
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // generator opens a message with strobe and address
    sequence s_addr;
        ads_oe_gen && address_strobe;
    endsequence
    // data word out, bridge not yet ready
    sequence s_stall;
        lad_oe_gen && !address_strobe && !ready_brg;
    endsequence
    property p_data_next;
        s_addr |=> lad_oe_gen && !address_strobe;
    endproperty
    a_data_next: assert property (p_data_next)
        else $error("no data word one clock after strobe");
    // bridge paces the word, so it must not move from the first stalled cycle to the next
    property p_data_held;
        s_addr ##1 s_stall |=> $stable(muxed_addr_data_lines);
    endproperty
    a_data_held: assert property (p_data_held)
        else $error("message data moved before ready");
    property p_grant;
        $rose(bus_hold_request) |-> ##[1:300] bus_hold_grant;
    endproperty
    a_grant: assert property (p_grant)
        else $error("hold request never granted");
    property p_owner;
        s_addr |-> !bus_hold_grant && !lad_oe_brg;
    endproperty
    a_owner: assert property (p_owner)
        else $error("generator mastered while bus granted");
    property p_grant_keep;
        bus_hold_grant && bus_hold_request |=> bus_hold_grant;
    endproperty
    a_grant_keep: assert property (p_grant_keep)
        else $error("grant dropped under held request");
    property p_ready_one;
        ready_gen |=> !ready_gen;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("slave ready longer than one cycle");
    property p_ready_sel;
        $rose(ready_gen) |-> $past(sel) && bus_hold_grant;
    endproperty
    a_ready_sel: assert property (p_ready_sel)
        else $error("slave ready without select");
    // a rejected word must be sent again soon
    property p_retry;
        message_rejected |-> ##[1:40] s_addr;
    endproperty
    a_retry: assert property (p_retry)
        else $error("rejected message not resent");
    property p_quiet_reset;
        $rose(i_rst_n) |-> !ads_oe_gen [*8];
    endproperty
    a_quiet_reset: assert property (p_quiet_reset)
        else $error("bus traffic right after reset");
endmodule : img_sva

// ### testbench/test_interrupt_message_generator.sv
// self-checking bench: generator and bridge joined through the link interface
// assumes 50 MHz clock; bench plays the controller and the bridge's far bus
module test_interrupt_message_generator;
    timeunit 1ns;
    timeprecision 1ps;
    // region addresses and the stored message for vector 5
    localparam logic [31:0] PIC_A = 32'h0000_0800;
    localparam logic [31:0] MASK_A = 32'h0000_1000;
    localparam logic [31:0] UNMASK_A = 32'h0000_1800;
    localparam logic [7:0] VEC = 8'h05;
    localparam logic [31:0] A_MSG = 32'h0000_0028;
    localparam logic [31:0] W_ADDR = {4'h0, img_pkg::MSG_TYPE_CODE, VEC, 16'h0000};
    localparam logic [31:0] W_DATA = 32'h1234_5678;
    // stimulus
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic pic_req = 1'b0;
    logic [7:0] pic_data = 8'h00;
    logic msg_accept = 1'b0;
    logic msg_nack = 1'b0;
    logic acc_req = 1'b0;
    logic acc_wr = 1'b0;
    logic [31:0] acc_addr = 32'h0000_0000;
    logic [31:0] acc_wdata = 32'h0000_0000;
    // design outputs
    logic ack, pic_rd, pic_wr, pic_a0, masked, msg_valid, acc_done;
    logic [7:0] pic_wdata;
    logic [31:0] msg_addr, msg_data, acc_rdata;
    // monitor state
    logic ack_d = 1'b0;
    logic [7:0] pic_wd;
    logic a0_seen;
    logic [31:0] wire_addr;
    int n_ack = 0;
    int n_msg = 0;
    int n_ads = 0;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    img_if bus_if ();
    img_gen i_img_gen (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus_if),
        .i_pic_req(pic_req), .i_pic_data(pic_data), .o_pic_ack_pulse(ack),
        .o_pic_rd(pic_rd), .o_pic_wr(pic_wr), .o_pic_cs(), .o_pic_a0(pic_a0),
        .o_pic_data(pic_wdata), .o_pic_data_oe(), .o_masked(masked));
    img_brg i_img_brg (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(bus_if),
        .i_msg_accept(msg_accept), .i_msg_nack(msg_nack), .o_msg_valid(msg_valid),
        .o_msg_addr(msg_addr), .o_msg_data(msg_data), .i_acc_req(acc_req),
        .i_acc_wr(acc_wr), .i_acc_addr(acc_addr), .i_acc_wdata(acc_wdata),
        .o_acc_done(acc_done), .o_acc_rdata(acc_rdata));
    img_sva i_img_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .muxed_addr_data_lines(bus_if.muxed_addr_data_lines),
        .lad_oe_gen(bus_if.lad_oe_gen), .lad_oe_brg(bus_if.lad_oe_brg), .address_strobe(bus_if.address_strobe),
        .ads_oe_gen(bus_if.ads_oe_gen), .ready_brg(bus_if.ready_brg),
        .ready_gen(bus_if.ready_gen), .message_rejected(bus_if.message_rejected),
        .bus_hold_request(bus_if.bus_hold_request), .bus_hold_grant(bus_if.bus_hold_grant),
        .sel(bus_if.sel));
    // 20 ns clock
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // pulse counts, controller strobes, wire address, hang limit
    always @(posedge i_ref_clk) begin
        ack_d <= ack;
        if (ack === 1'b1 && ack_d !== 1'b1) n_ack++;
        if (msg_valid === 1'b1) n_msg++;
        if (pic_wr === 1'b1) pic_wd <= pic_wdata;
        if (pic_wr === 1'b1 || pic_rd === 1'b1) a0_seen <= pic_a0;
        if (bus_if.ads_oe_gen === 1'b1 && bus_if.address_strobe === 1'b1) wire_addr <= bus_if.muxed_addr_data_lines;
        if (bus_if.ads_oe_gen === 1'b1) n_ads++;
        cyc++;
        // far above the thousand or so cycles the tests need
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one slave access through the bridge, request held until done
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        int n;
        @(posedge i_ref_clk);
        acc_req <= 1'b1;
        acc_wr <= wr;
        acc_addr <= a;
        acc_wdata <= wd;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (acc_done !== 1'b1 && n < 300);
        rd = acc_rdata;
        chk(32'(n < 300), 32'h0000_0001);
        acc_req <= 1'b0;
    endtask : acc
    // wait for a generator strobe, then two clocks so the bridge holds both words
    task automatic wait_msg;
        int n;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (!(bus_if.ads_oe_gen === 1'b1 && bus_if.address_strobe === 1'b1) && n < 2000);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(n < 2000), 32'h0000_0001);
    endtask : wait_msg
    // request while masked must stay silent
    task automatic quiet_req;
        n_ack = 0;
        n_msg = 0;
        pic_req <= 1'b1;
        repeat (200) @(posedge i_ref_clk);
        pic_req <= 1'b0;
        chk(32'(n_ack), 32'h0000_0000);
        chk(32'(n_msg), 32'h0000_0000);
    endtask : quiet_req
    task automatic t_reset;
        @(posedge i_ref_clk);
        chk(masked, 1'b1);
        chk(bus_if.ads_oe_gen, 1'b0);
        quiet_req;
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ram;
        logic [31:0] r;
        acc(1'b1, A_MSG, W_ADDR, r);
        acc(1'b1, A_MSG + 32'h0000_0004, W_DATA, r);
        acc(1'b0, A_MSG, 32'h0000_0000, r);
        chk(r, W_ADDR);
        acc(1'b0, A_MSG + 32'h0000_0004, 32'h0000_0000, r);
        chk(r, W_DATA);
        $display("t_ram done");
    endtask : t_ram
    task automatic t_pic;
        logic [31:0] r;
        acc(1'b1, PIC_A + 32'h0000_0004, 32'h0000_00a5, r);
        chk(pic_wd, 8'ha5);
        chk(a0_seen, 1'b1);
        pic_data <= 8'h3c;
        acc(1'b0, PIC_A, 32'h0000_0000, r);
        chk(r[7:0], 8'h3c);
        chk(a0_seen, 1'b0);
        $display("t_pic done");
    endtask : t_pic
    // unmask, fetch vector, reject once, then accept
    task automatic t_msg;
        logic [31:0] r;
        acc(1'b1, UNMASK_A, 32'h0000_0000, r);
        chk(masked, 1'b0);
        pic_data <= VEC;
        n_ack = 0;
        n_ads = 0;
        pic_req <= 1'b1;
        wait_msg;
        pic_req <= 1'b0;
        chk(msg_addr, W_ADDR);
        chk(msg_data, W_DATA);
        chk(wire_addr, W_ADDR);
        chk(32'(n_ack), 32'h0000_0002);
        msg_nack <= 1'b1;
        @(posedge i_ref_clk);
        msg_nack <= 1'b0;
        wait_msg;
        chk(32'(n_ads), 32'h0000_0002);
        chk(msg_addr, W_ADDR);
        chk(msg_data, W_DATA);
        msg_accept <= 1'b1;
        @(posedge i_ref_clk);
        msg_accept <= 1'b0;
        n_msg = 0;
        repeat (300) @(posedge i_ref_clk);
        chk(32'(n_msg), 32'h0000_0001);
        chk(32'(n_ads), 32'h0000_0002);
        chk(32'(n_ack), 32'h0000_0002);
        $display("t_msg done");
    endtask : t_msg
    task automatic t_mask;
        logic [31:0] r;
        acc(1'b1, MASK_A, 32'h0000_0000, r);
        chk(masked, 1'b1);
        quiet_req;
        $display("t_mask done");
    endtask : t_mask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // reset for four cycles, then the tests in turn
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_ram;
        t_pic;
        t_msg;
        t_mask;
        test_done;
    end
endmodule : test_interrupt_message_generator
